/* File: hw/reset_source_controller.sv */
// reset source controller: pin clear, supply monitor, watchdog resets
// assumes an AHB-Lite master on CLOCK and a same-clock watchdog pulse
//
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module reset_source_controller #(
  parameter int POR_HOLD = rsc_pkg::POR_HOLD_CYC,
  parameter int EXT_HOLD = rsc_pkg::EXT_HOLD_CYC,
  parameter int LV_HOLD  = rsc_pkg::LV_HOLD_CYC,
  parameter int WDT_HOLD = rsc_pkg::WDT_HOLD_CYC,
  parameter logic [7:0] LV_MIN = 8'(rsc_pkg::LV_MIN_TICKS)
) (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        EXT_CLEAR_PIN_N,
  input  wire logic        LOW_SUPPLY,
  input  wire logic        LOW_SPEED_INTERNAL_OSC_CLK,
  input  wire logic        WDT_TIMEOUT,
  input  wire logic [1:0]  POWER_MODE,
  input  wire logic [1:0]  CLOCK_SOURCE,
  input  wire logic        FLAG_CLEAR,
  output logic             CORE_RESET,
  output logic             STARTUP_WAIT,
  output logic             PC_CLEAR,
  output logic             SP_CLEAR,
  output logic             SP_TOP,
  output logic             INT_DISABLE,
  output logic             WDT_CLEAR,
  output logic             TIMER_OFF,
  output logic             PORTS_INPUT,
  output logic             ANALOG_INPUTS,
  output logic             MONITOR_ENABLE,
  output logic [1:0]       TRIP_LEVEL
);

  ////////////////////////////////////////////////////////////////////////
  // helpers
  // {valid, level code} of a select value
  function automatic logic [2:0] trip_decode(input logic [7:0] s);
    logic [2:0] r;
    r = 3'h0;
    if (s == rsc_pkg::SEL_2V10) begin
      r = 3'h4;
    end else if (s == rsc_pkg::SEL_2V55) begin
      r = 3'h5;
    end else if (s == rsc_pkg::SEL_3V15) begin
      r = 3'h6;
    end else if (s == rsc_pkg::SEL_3V80) begin
      r = 3'h7;
    end
    return r;
  endfunction

  function automatic logic [rsc_pkg::HOLD_W-1:0] sst_len(input logic [1:0] src);
    logic [rsc_pkg::HOLD_W-1:0] n;
    case (src)
      rsc_pkg::SRC_HXT:  n = rsc_pkg::SST_HXT_CYC;
      rsc_pkg::SRC_LOW_SPEED_INTERNAL_OSC: n = rsc_pkg::SST_LOW_SPEED_INTERNAL_OSC_CYC;
      default:           n = rsc_pkg::SST_HIGH_SPEED_INTERNAL_OSC_CYC;
    endcase
    return n - 22'h000001;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] sync_q;
  logic       pin_s;
  logic       low_s;
  logic       low_speed_internal_osc_s;

  rsc_sync #(
    .W   (3),
    .INI (3'h4)
  ) u_sync (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .d     ({EXT_CLEAR_PIN_N, LOW_SUPPLY, LOW_SPEED_INTERNAL_OSC_CLK}),
    .q     (sync_q)
  );

  assign pin_s  = sync_q[2];
  assign low_s  = sync_q[1];
  assign low_speed_internal_osc_s = sync_q[0];
  ////////////////////////////////////////////////////////////////////////
  // state
  rsc_pkg::state_t             state_r;
  rsc_pkg::state_t             state_nxt;
  logic [rsc_pkg::HOLD_W-1:0]  cnt_r;
  logic [rsc_pkg::HOLD_W-1:0]  cnt_nxt;
  logic [7:0]                  sel_r;
  logic [7:0]                  sel_nxt;
  logic                        thr_r;
  logic                        thr_nxt;
  logic                        lvf_r;
  logic                        lvf_nxt;
  logic                        pinen_r;
  logic                        pinen_nxt;
  logic                        exp_r;
  logic                        exp_nxt;
  logic                        pd_r;
  logic                        pd_nxt;
  logic                        pc_r;
  logic                        pc_nxt;
  logic                        sp_r;
  logic                        sp_nxt;
  logic                        por_r;
  logic                        mon_r;
  logic                        mon_nxt;
  logic                        low_speed_internal_osc_d_r;
  logic [7:0]                  lv_cnt_r;
  logic [7:0]                  lv_cnt_nxt;
  logic [1:0]                  bad_cnt_r;
  logic [1:0]                  bad_cnt_nxt;
  logic                        wr_r;
  logic                        wr_nxt;
  logic                        rd_r;
  logic                        rd_nxt;
  logic [7:0]                  addr_r;
  logic [7:0]                  addr_nxt;

  logic tick;
  logic pin_low;
  logic sel_ok;
  logic lv_fire;
  logic bad_fire;
  logic in_pd;
  logic run;
  logic [2:0] trip_dec;
  assign tick    = low_speed_internal_osc_s & ~low_speed_internal_osc_d_r;
  assign pin_low = pinen_r & ~pin_s;
  assign trip_dec = trip_decode(sel_r);
  assign sel_ok  = trip_dec[2];
  assign in_pd   = (POWER_MODE == rsc_pkg::MODE_IDLE) || (POWER_MODE == rsc_pkg::MODE_SLEEP);
  assign run     = (state_r == rsc_pkg::ST_RUN);
  // fires on the tick after the low level has already lasted LV_MIN ticks
  assign lv_fire  = tick & low_s & mon_r & (lv_cnt_r == LV_MIN);
  assign bad_fire = tick & ~sel_ok & (bad_cnt_r == rsc_pkg::BAD_SEL_TICKS - 2'h1);
  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    sel_nxt     = sel_r;
    thr_nxt     = thr_r;
    lvf_nxt     = lvf_r;
    pinen_nxt   = pinen_r;
    exp_nxt     = exp_r;
    pd_nxt      = pd_r;
    pc_nxt      = 1'b0;
    sp_nxt      = 1'b0;
    mon_nxt     = ~in_pd;
    lv_cnt_nxt  = 8'h00;
    bad_cnt_nxt = 2'h0;
    wr_nxt      = 1'b0;
    rd_nxt      = 1'b0;
    addr_nxt    = addr_r;
    // address phase
    if (HSEL && HREADY && HTRANS[1]) begin
      wr_nxt   = HWRITE;
      rd_nxt   = ~HWRITE;
      addr_nxt = (HADDR[31:8] == 24'h000000) ? HADDR[7:0] : rsc_pkg::OFF_NONE;
    end
    // data phase writes; any hardware set below overrides a clear here
    if (wr_r) begin
      if (addr_r == rsc_pkg::OFF_SELECT) begin
        sel_nxt = HWDATA[7:0];
      end else if (addr_r == rsc_pkg::OFF_FLAGS) begin
        if (!HWDATA[rsc_pkg::FLG_THR_BIT]) begin
          thr_nxt = 1'b0;
        end
        if (!HWDATA[rsc_pkg::FLG_LV_BIT]) begin
          lvf_nxt = 1'b0;
        end
        pinen_nxt = HWDATA[rsc_pkg::FLG_PINEN_BIT];
      end
    end
    if (FLAG_CLEAR) begin
      exp_nxt = 1'b0;
      pd_nxt  = 1'b0;
    end
    // qualification counts only while running
    if (run && mon_r && low_s) begin
      lv_cnt_nxt = lv_cnt_r;
      if (tick && lv_cnt_r != 8'hFF) begin
        lv_cnt_nxt = lv_cnt_r + 8'h01;
      end
    end
    if (run && !sel_ok) begin
      bad_cnt_nxt = bad_cnt_r;
      if (tick) begin
        bad_cnt_nxt = bad_cnt_r + 2'h1;
      end
    end
    case (state_r)
      rsc_pkg::ST_RUN: begin
        if (pin_low) begin
          state_nxt = rsc_pkg::ST_PIN;
          pc_nxt    = 1'b1;
        end else if (bad_fire) begin
          state_nxt = rsc_pkg::ST_HOLD;
          cnt_nxt   = rsc_pkg::HOLD_W'(LV_HOLD - 1);
          sel_nxt   = rsc_pkg::SEL_POR;
          thr_nxt   = 1'b1;
          pc_nxt    = 1'b1;
        end else if (lv_fire) begin
          // select value kept as written
          state_nxt = rsc_pkg::ST_HOLD;
          cnt_nxt   = rsc_pkg::HOLD_W'(LV_HOLD - 1);
          lvf_nxt   = 1'b1;
          pc_nxt    = 1'b1;
        end else if (WDT_TIMEOUT) begin
          exp_nxt = 1'b1;
          pc_nxt  = 1'b1;
          if (in_pd) begin
            pd_nxt    = 1'b1;
            sp_nxt    = 1'b1;
            state_nxt = rsc_pkg::ST_SST;
            cnt_nxt   = sst_len(CLOCK_SOURCE);
          end else begin
            state_nxt = rsc_pkg::ST_HOLD;
            cnt_nxt   = rsc_pkg::HOLD_W'(WDT_HOLD - 1);
            sel_nxt   = rsc_pkg::SEL_POR;
          end
        end
      end
      rsc_pkg::ST_PIN: begin
        // flags untouched by the pin reset
        if (!pin_low) begin
          state_nxt = rsc_pkg::ST_HOLD;
          cnt_nxt   = rsc_pkg::HOLD_W'(EXT_HOLD - 1);
          sel_nxt   = rsc_pkg::SEL_POR;
        end
      end
      rsc_pkg::ST_HOLD, rsc_pkg::ST_SST: begin
        if (pin_low) begin
          state_nxt = rsc_pkg::ST_PIN;
          pc_nxt    = 1'b1;
        end else if (cnt_r == 22'h000000) begin
          state_nxt = rsc_pkg::ST_RUN;
        end else begin
          cnt_nxt = cnt_r - 22'h000001;
        end
      end
      default: begin
        state_nxt = rsc_pkg::ST_RUN;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state_r   <= rsc_pkg::ST_HOLD;
      cnt_r     <= rsc_pkg::HOLD_W'(POR_HOLD - 1);
      sel_r     <= rsc_pkg::SEL_POR;
      thr_r     <= 1'b0;
      lvf_r     <= 1'b0;
      pinen_r   <= rsc_pkg::PINEN_POR;
      exp_r     <= 1'b0;
      pd_r      <= 1'b0;
      pc_r      <= 1'b1;
      sp_r      <= 1'b0;
      por_r     <= 1'b1;
      mon_r     <= 1'b1;
      low_speed_internal_osc_d_r  <= 1'b0;
      lv_cnt_r  <= 8'h00;
      bad_cnt_r <= 2'h0;
      wr_r      <= 1'b0;
      rd_r      <= 1'b0;
      addr_r    <= rsc_pkg::OFF_NONE;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      sel_r     <= sel_nxt;
      thr_r     <= thr_nxt;
      lvf_r     <= lvf_nxt;
      pinen_r   <= pinen_nxt;
      exp_r     <= exp_nxt;
      pd_r      <= pd_nxt;
      pc_r      <= pc_nxt;
      sp_r      <= sp_nxt;
      por_r     <= 1'b0;
      mon_r     <= mon_nxt;
      low_speed_internal_osc_d_r  <= low_speed_internal_osc_s;
      lv_cnt_r  <= lv_cnt_nxt;
      bad_cnt_r <= bad_cnt_nxt;
      wr_r      <= wr_nxt;
      rd_r      <= rd_nxt;
      addr_r    <= addr_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // bus read path, zero wait states
  // read mux sits in the data phase so a write just before is seen
  always_comb begin
    HRDATA = 32'h00000000;
    if (rd_r) begin
      if (addr_r == rsc_pkg::OFF_SELECT) begin
        HRDATA[7:0] = sel_r;
      end else if (addr_r == rsc_pkg::OFF_FLAGS) begin
        HRDATA[rsc_pkg::FLG_THR_BIT]   = thr_r;
        HRDATA[rsc_pkg::FLG_LV_BIT]    = lvf_r;
        HRDATA[rsc_pkg::FLG_PINEN_BIT] = pinen_r;
      end else if (addr_r == rsc_pkg::OFF_STATUS) begin
        HRDATA[rsc_pkg::ST_EXP_BIT]  = exp_r;
        HRDATA[rsc_pkg::ST_PD_BIT]   = pd_r;
        HRDATA[rsc_pkg::ST_HOLD_BIT] = CORE_RESET;
        HRDATA[rsc_pkg::ST_SST_BIT]  = STARTUP_WAIT;
      end
    end
  end
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // core-side outputs
  assign CORE_RESET    = (state_r == rsc_pkg::ST_PIN) || (state_r == rsc_pkg::ST_HOLD);
  assign STARTUP_WAIT  = (state_r == rsc_pkg::ST_SST);
  assign PC_CLEAR      = pc_r;
  assign SP_CLEAR      = sp_r;
  // power-on initial conditions, high while RESETN is low, cleared on the first clock after its release
  assign SP_TOP        = por_r;
  assign INT_DISABLE   = por_r;
  assign WDT_CLEAR     = por_r;
  assign TIMER_OFF     = por_r;
  assign PORTS_INPUT   = por_r;
  assign ANALOG_INPUTS = por_r;
  assign MONITOR_ENABLE = mon_r;
  assign TRIP_LEVEL    = trip_dec[1:0];

endmodule
`default_nettype wire

/* File: hw/rsc_pkg.sv */
// constants, field positions and types of the reset source controller
// assumes a 25 MHz system clock and a word-wide AHB-Lite register port
package rsc_pkg;

  localparam int CLK_HZ      = 25_000_000;
  localparam int CLK_PER_US  = CLK_HZ / 1_000_000;

  // hold times in microseconds, typical figures
  localparam int EXT_HOLD_US = 100_000;
  localparam int LV_HOLD_US  = 16_700;
  localparam int WDT_HOLD_US = 50_000;
  localparam int POR_HOLD_US = 50_000;

  localparam int EXT_HOLD_CYC = EXT_HOLD_US * CLK_PER_US;
  localparam int LV_HOLD_CYC  = LV_HOLD_US * CLK_PER_US;
  localparam int WDT_HOLD_CYC = WDT_HOLD_US * CLK_PER_US;
  localparam int POR_HOLD_CYC = POR_HOLD_US * CLK_PER_US;
  localparam int HOLD_W       = 22;

  // start-up timer lengths in system clocks, upper figure of each range
  localparam logic [HOLD_W-1:0] SST_HIGH_SPEED_INTERNAL_OSC_CYC = 22'h00010;
  localparam logic [HOLD_W-1:0] SST_HXT_CYC  = 22'h00080;
  localparam logic [HOLD_W-1:0] SST_LOW_SPEED_INTERNAL_OSC_CYC = 22'h00002;

  // low-speed oscillator ticks
  localparam int           LV_MIN_TICKS  = 4;
  localparam logic [1:0]   BAD_SEL_TICKS = 2'h2;

  localparam logic [7:0] SEL_POR  = 8'h55;
  localparam logic [7:0] SEL_2V10 = 8'h55;
  localparam logic [7:0] SEL_2V55 = 8'h33;
  localparam logic [7:0] SEL_3V15 = 8'h99;
  localparam logic [7:0] SEL_3V80 = 8'hAA;

  localparam logic [7:0] OFF_SELECT = 8'h00;
  localparam logic [7:0] OFF_FLAGS  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_NONE   = 8'hFF;

  localparam int FLG_THR_BIT   = 0;
  localparam int FLG_LV_BIT    = 1;
  localparam int FLG_PINEN_BIT = 2;
  localparam int ST_EXP_BIT    = 0;
  localparam int ST_PD_BIT     = 1;
  localparam int ST_HOLD_BIT   = 2;
  localparam int ST_SST_BIT    = 3;

  localparam logic PINEN_POR = 1'b1;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_SLOW   = 2'h1,
    MODE_IDLE   = 2'h2,
    MODE_SLEEP  = 2'h3
  } pmode_t;

  typedef enum logic [1:0] {
    SRC_HIGH_SPEED_INTERNAL_OSC = 2'h0,
    SRC_HXT  = 2'h1,
    SRC_LOW_SPEED_INTERNAL_OSC = 2'h2
  } csrc_t;

  typedef enum logic [3:0] {
    ST_RUN  = 4'h1,
    ST_PIN  = 4'h2,
    ST_HOLD = 4'h4,
    ST_SST  = 4'h8
  } state_t;

endpackage

/* File: hw/rsc_sync.sv */
// two-flop synchroniser for a group of unrelated pin levels
// assumes each bit is a slow level; no bus coherence between bits
`timescale 1ns/1ps
`default_nettype none
module rsc_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] INI = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= INI;
      q_r    <= INI;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q = q_r;

endmodule
`default_nettype wire

/* File: verification/rsc_checker_properties.sv */
// port-level checks of the reset source controller
// assumes the shortened holds of the bench, all of them above 8 cycles
`timescale 1ns/1ps
`default_nettype none
module rsc_checker (
  input wire logic        CLOCK,
  input wire logic        RESETN,
  input wire logic        HSEL,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        WDT_TIMEOUT,
  input wire logic [1:0]  POWER_MODE,
  input wire logic [1:0]  CLOCK_SOURCE,
  input wire logic        CORE_RESET,
  input wire logic        STARTUP_WAIT,
  input wire logic        PC_CLEAR,
  input wire logic        SP_CLEAR,
  input wire logic        SP_TOP,
  input wire logic        INT_DISABLE,
  input wire logic        WDT_CLEAR,
  input wire logic        TIMER_OFF,
  input wire logic        PORTS_INPUT,
  input wire logic        ANALOG_INPUTS,
  input wire logic        MONITOR_ENABLE
);
  logic por_all;
  logic run;
  assign por_all = SP_TOP && INT_DISABLE && WDT_CLEAR && TIMER_OFF && PORTS_INPUT && ANALOG_INPUTS;
  assign run     = !CORE_RESET && !STARTUP_WAIT;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  //////////////////////////////////////////////////////////////////////
  a_por_conditions: assert property ($rose(RESETN) |-> por_all ##1 !por_all)
    else $error("power-on conditions wrong after reset release");
  a_pc_on_reset: assert property ($rose(CORE_RESET) |-> ##[0:1] PC_CLEAR)
    else $error("program counter clear missing at core reset");
  a_hold_minimum: assert property ($rose(CORE_RESET) |-> CORE_RESET[*8])
    else $error("core reset hold too short");
  a_wdt_normal: assert property (WDT_TIMEOUT && run && !POWER_MODE[1] |=> CORE_RESET)
    else $error("normal watchdog expiry gave no core reset");
  a_wdt_sleep: assert property (WDT_TIMEOUT && run && POWER_MODE[1] |=> (SP_CLEAR && STARTUP_WAIT) || CORE_RESET)
    else $error("sleep watchdog expiry gave no pointer clear");
  a_sp_pulse: assert property (SP_CLEAR |-> PC_CLEAR && STARTUP_WAIT && !CORE_RESET ##1 !SP_CLEAR)
    else $error("stack pointer clear not a lone pulse");
  a_sst_slow: assert property ($rose(STARTUP_WAIT) && CLOCK_SOURCE == rsc_pkg::SRC_LOW_SPEED_INTERNAL_OSC
    |-> STARTUP_WAIT[*2] ##1 !STARTUP_WAIT)
    else $error("slow oscillator start-up length wrong");
  a_monitor_off: assert property (POWER_MODE[1] |=> !MONITOR_ENABLE)
    else $error("supply monitor left on in power down");
  a_monitor_on: assert property (!POWER_MODE[1] |=> MONITOR_ENABLE)
    else $error("supply monitor off in a running mode");
  a_bus_okay: assert property (HSEL && HTRANS[1] && HREADY |=> HREADYOUT && !HRESP)
    else $error("bus transfer not answered okay");
  a_rdata_idle: assert property (!(HSEL && HTRANS[1] && HREADY && !HWRITE) |=> HRDATA == 32'h0)
    else $error("read data outside a read data phase");
endmodule
bind reset_source_controller rsc_checker u_chk (
  .CLOCK, .RESETN, .HSEL, .HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .WDT_TIMEOUT,
  .POWER_MODE, .CLOCK_SOURCE, .CORE_RESET, .STARTUP_WAIT, .PC_CLEAR, .SP_CLEAR, .SP_TOP,
  .INT_DISABLE, .WDT_CLEAR, .TIMER_OFF, .PORTS_INPUT, .ANALOG_INPUTS, .MONITOR_ENABLE
);
`default_nettype wire

/* File: verification/rsc_pin_network.sv */
// external clear pin network, supply comparator and slow oscillator
// assumes the bench commands pin pull-down and low supply as levels
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_network (
  input  wire logic pull_low,
  input  wire logic supply_low,
  output logic      pin_n,
  output logic      low_supply,
  output logic      low_speed_internal_osc_clk
);
  // pull-up resistor: a released pin reads high
  assign pin_n      = pull_low ? 1'b0 : 1'b1;
  assign low_supply = supply_low;
  // free-running slow oscillator, 20 system clocks a period
  initial low_speed_internal_osc_clk = 1'b0;
  always #400 low_speed_internal_osc_clk = ~low_speed_internal_osc_clk;
endmodule
`default_nettype wire

/* File: verification/tb_reset_source_controller.sv */
// self-checking bench of the reset source controller over AHB-Lite
// assumes shortened hold parameters and a slow oscillator from the pin model
`timescale 1ns/1ps
`default_nettype none
module tb_reset_source_controller;
  localparam int EXT = 40;
  localparam int LVH = 30;
  localparam int WDH = 50;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire  logic  hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic        pull_low = 1'b0;
  logic        supply_low = 1'b0;
  logic        pin_n, low_sup, low_speed_internal_osc;
  logic        wdt_to = 1'b0;
  logic [1:0]  pmode = 2'h0;
  logic [1:0]  csrc = 2'h0;
  logic        flag_clr = 1'b0;
  logic        core_reset, startup_wait;
  logic [1:0]  trip;
  int          n_errors = 0;
  int          total_checks = 0;
  int          n;
  logic [7:0]  sels [4] = '{8'h55, 8'h99, 8'hAA, 8'h33};
  logic [1:0]  lvls [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  int          lo [3] = '{15, 128, 1};
  int          hi [3] = '{16, 128, 2};
  always #20 clock = ~clock;
  rsc_pin_network u_net (.pull_low(pull_low), .supply_low(supply_low), .pin_n(pin_n),
    .low_supply(low_sup), .low_speed_internal_osc_clk(low_speed_internal_osc));
  reset_source_controller #(.POR_HOLD(20), .EXT_HOLD(EXT), .LV_HOLD(LVH), .WDT_HOLD(WDH), .LV_MIN(8'h02)) dut (
    .CLOCK(clock), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .EXT_CLEAR_PIN_N(pin_n), .LOW_SUPPLY(low_sup), .LOW_SPEED_INTERNAL_OSC_CLK(low_speed_internal_osc), .WDT_TIMEOUT(wdt_to),
    .POWER_MODE(pmode), .CLOCK_SOURCE(csrc), .FLAG_CLEAR(flag_clr), .CORE_RESET(core_reset),
    .STARTUP_WAIT(startup_wait), .PC_CLEAR(), .SP_CLEAR(), .SP_TOP(), .INT_DISABLE(), .WDT_CLEAR(),
    .TIMER_OFF(), .PORTS_INPUT(), .ANALOG_INPUTS(), .MONITOR_ENABLE(), .TRIP_LEVEL(trip));
  //////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_range(input string what, input int lo_v, input int hi_v, input int got);
    total_checks++;
    if (got < lo_v || got > hi_v) begin
      n_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo_v, hi_v, got);
    end
  endtask
  task automatic ahb_cycle(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] unused;
    ahb_cycle(1'b1, a, v, unused);
  endtask
  task automatic rd_check(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahb_cycle(1'b0, a, 32'h0, v);
    check(what, exp, v);
  endtask
  // bounded wait on the core reset level, counting edges
  task automatic wait_core(input logic v, output int cnt);
    cnt = 0;
    while (core_reset !== v && cnt < 2000) begin
      @(posedge clock);
      cnt++;
    end
  endtask
  task automatic pulse_wdt;
    @(posedge clock);
    wdt_to <= 1'b1;
    @(posedge clock);
    wdt_to <= 1'b0;
  endtask
  task automatic pulse_clr;
    @(posedge clock);
    flag_clr <= 1'b1;
    @(posedge clock);
    flag_clr <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 30000);
    n_errors++;
    $display("[FAIL] watchdog expected completion seen hang");
    final_report();
  end
  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    rd_check("select_por", 32'h00, 32'h55);
    rd_check("flags_por", 32'h04, 32'h4);
    rd_check("status_hold", 32'h08, 32'h4);
    wait_core(1'b0, n);
    rd_check("status_por", 32'h08, 32'h0);
    rd_check("unmapped", 32'h40, 32'h0);
    // slow mode must behave as normal running
    pmode <= 2'h1;
    pulse_wdt();
    wait_core(1'b1, n);
    check_range("wdt_rise", 1, 2, n);
    wait_core(1'b0, n);
    check_range("wdt_hold", WDH - 1, WDH + 1, n);
    rd_check("status_wdt", 32'h08, 32'h1);
    @(posedge clock) pull_low <= 1'b1;
    repeat (10) @(posedge clock);
    check("pin_reset", 32'h1, {31'h0, core_reset});
    pull_low <= 1'b0;
    wait_core(1'b0, n);
    check_range("pin_hold", EXT, EXT + 4, n);
    rd_check("status_pin", 32'h08, 32'h1);
    pulse_clr();
    rd_check("status_clr", 32'h08, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(32'h00, {24'h0, sels[i]});
      @(posedge clock);
      check("trip_level", {30'h0, lvls[i]}, {30'h0, trip});
      rd_check("select_rb", 32'h00, {24'h0, sels[i]});
    end
    @(posedge clock) supply_low <= 1'b1;
    repeat (15) @(posedge clock);
    supply_low <= 1'b0;
    repeat (60) @(posedge clock);
    check("short_low", 32'h0, {31'h0, core_reset});
    supply_low <= 1'b1;
    wait_core(1'b1, n);
    check_range("lv_qualify", 40, 100, n);
    supply_low <= 1'b0;
    wait_core(1'b0, n);
    check_range("lv_hold", LVH - 1, LVH + 1, n);
    rd_check("flags_lv", 32'h04, 32'h6);
    rd_check("select_kept", 32'h00, 32'h33);
    rd_check("status_lv", 32'h08, 32'h0);
    wr(32'h04, 32'h4);
    rd_check("flags_swclr", 32'h04, 32'h4);
    wr(32'h00, 32'h12);
    wait_core(1'b1, n);
    check_range("bad_sel_delay", 20, 70, n);
    wait_core(1'b0, n);
    rd_check("flags_bad", 32'h04, 32'h5);
    rd_check("select_restored", 32'h00, 32'h55);
    wr(32'h04, 32'h4);
    for (int s = 0; s < 3; s++) begin
      @(posedge clock);
      pmode <= {1'b1, s[0]};
      csrc <= s[1:0];
      pulse_wdt();
      n = 0;
      @(posedge clock);
      while (startup_wait === 1'b1 && n < 300) begin
        n++;
        @(posedge clock);
      end
      check_range("startup_len", lo[s], hi[s], n);
      check("sleep_no_core", 32'h0, {31'h0, core_reset});
      rd_check("status_sleep", 32'h08, 32'h3);
      pulse_clr();
    end
    @(posedge clock) pmode <= 2'h0;
    wr(32'h04, 32'h0);
    @(posedge clock) pull_low <= 1'b1;
    repeat (10) @(posedge clock);
    check("pin_disabled", 32'h0, {31'h0, core_reset});
    pull_low <= 1'b0;
    repeat (4) @(posedge clock);
    wr(32'h04, 32'h4);
    final_report();
  end
endmodule
`default_nettype wire
